// ==== rtl/dapr_top.sv ====
// module: control and parallel readout of a dual simultaneous-sampling converter
`timescale 1ns/1ns

module dapr_top
  import dapr_pkg::*;
(
  input  wire logic                   sys_clk_in,
  input  wire logic                   srst_in,
  input  wire dapr_pkg::dapr_ctrl_t   ctrl_in,
  input  wire dapr_pkg::dapr_samples_t analog_in,
  output logic                        busy_out,
  output dapr_pkg::dapr_word_t        data_out,
  output logic                        data_oe_out
);
  import dapr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dapr_st_t st;
  dapr_st_t next_st;

  // one step of the conversion counter
  localparam logic [TICK_W-1:0] TICK_ONE = 5'h01;

  // reset image: idle, start and read strobes seen high, conversion clock seen low, results cleared
  localparam dapr_st_t ST_RESET = '{
    state:       DAPR_IDLE,
    ticks:       TICKS_ZERO,
    pair_sel:    1'b0,
    hold_a:      WORD_ZERO,
    hold_b:      WORD_ZERO,
    results:     '{
      a_in0: WORD_ZERO,
      a_in1: WORD_ZERO,
      b_in0: WORD_ZERO,
      b_in1: WORD_ZERO
    },
    conv_n_d:    1'b1,
    clk_d:       1'b0,
    rd_n_d:      1'b1,
    read_b_next: 1'b0,
    busy:        1'b0,
    data:        WORD_ZERO,
    data_oe:     1'b0
  };

  // ----------------------------------------------------------------
  // word chosen by converter (A or B) and input select
  // ----------------------------------------------------------------
  function automatic dapr_word_t pick_word(input dapr_samples_t words,
                                           input logic          second,
                                           input logic          sel);
    dapr_word_t word;
    word = WORD_ZERO;
    case ({second, sel})
      2'b00: begin
        word = words.a_in0;
      end
      2'b01: begin
        word = words.a_in1;
      end
      2'b10: begin
        word = words.b_in0;
      end
      2'b11: begin
        word = words.b_in1;
      end
      default: begin
        word = WORD_ZERO;
      end
    endcase
    return word;
  endfunction

  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  logic              start_low;
  logic              start_fall;
  logic              start_taken;
  logic              clk_high;
  logic              clk_rise;
  logic              clk_step;
  logic              rd_active;
  logic              rd_fall;
  logic              conv_active;
  logic              conv_last;
  logic              store_now;
  logic [TICK_W-1:0] ticks_inc;

  assign start_low   = !ctrl_in.conversion_start_strobe_n;
  assign start_fall  = st.conv_n_d && start_low;
  assign conv_active = (st.state == DAPR_CONV);
  assign start_taken = start_fall && !conv_active;
  assign clk_high    = ctrl_in.conv_clk;
  assign clk_rise    = !st.clk_d && clk_high;
  assign clk_step    = conv_active && clk_rise;
  assign ticks_inc   = st.ticks + TICK_ONE;
  assign conv_last   = (ticks_inc == TICKS_DONE);
  assign store_now   = clk_step && conv_last;
  assign rd_active   = !ctrl_in.cs_n && !ctrl_in.rd_n;
  assign rd_fall     = st.rd_n_d && rd_active;

  // ----------------------------------------------------------------
  // sample selection
  // ----------------------------------------------------------------
  dapr_word_t pick_a;
  dapr_word_t pick_b;
  dapr_word_t read_word;

  assign pick_a    = pick_word(analog_in, 1'b0, ctrl_in.channel_select);
  assign pick_b    = pick_word(analog_in, 1'b1, ctrl_in.channel_select);
  assign read_word = pick_word(st.results, st.read_b_next, ctrl_in.channel_select);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;

    // ----------------------------------------------------------------
    // edge history, refreshed every cycle
    // ----------------------------------------------------------------
    next_st.conv_n_d = ctrl_in.conversion_start_strobe_n;
    next_st.clk_d    = clk_high;
    next_st.rd_n_d   = !rd_active;

    // ----------------------------------------------------------------
    // conversion control
    // ----------------------------------------------------------------
    case (st.state)
      DAPR_IDLE: begin
        next_st.busy = 1'b0;
        if (start_taken) begin
          next_st.pair_sel = ctrl_in.channel_select;
          next_st.hold_a   = pick_a;
          next_st.hold_b   = pick_b;
          next_st.ticks    = TICKS_ZERO;
          next_st.state    = DAPR_CONV;
          next_st.busy     = 1'b1;
        end
      end
      DAPR_CONV: begin
        next_st.busy = 1'b1;
        if (clk_step) begin
          next_st.ticks = ticks_inc;
          if (conv_last) begin
            next_st.state       = DAPR_IDLE;
            next_st.busy        = 1'b0;
            next_st.read_b_next = 1'b0;
          end
        end
      end
      default: begin
        next_st.state = DAPR_IDLE;
        next_st.busy  = 1'b0;
        next_st.ticks = TICKS_ZERO;
      end
    endcase

    // ----------------------------------------------------------------
    // result store at the end of a conversion
    // ----------------------------------------------------------------
    if (store_now) begin
      case (st.pair_sel)
        1'b0: begin
          next_st.results.a_in0 = st.hold_a;
          next_st.results.b_in0 = st.hold_b;
        end
        1'b1: begin
          next_st.results.a_in1 = st.hold_a;
          next_st.results.b_in1 = st.hold_b;
        end
        default: begin
          next_st.results = st.results;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // readout: falls alternate A then B, select picks input
    // ----------------------------------------------------------------
    if (rd_fall) begin
      next_st.data        = read_word;
      next_st.read_b_next = !st.read_b_next;
    end
    next_st.data_oe = rd_active;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs: bus bit 11 is the msb, bit 0 the lsb
  // ----------------------------------------------------------------
  dapr_word_t bus_bits;

  for (genvar bit_idx = 0; bit_idx < RES_W; bit_idx++) begin : g_bus_bit
    assign bus_bits[bit_idx] = st.data[bit_idx];
  end

  assign busy_out    = st.busy;
  assign data_out    = bus_bits;
  assign data_oe_out = st.data_oe;
endmodule

// ==== rtl/dapr_pkg.sv ====
// package: constants and carrier types for the dual converter readout
package dapr_pkg;
  localparam int unsigned RES_W          = 12;
  localparam int unsigned CLK_PER_SAMPLE = 16;
  localparam int unsigned CONV_TICKS     = 14;
  localparam int unsigned TICK_W         = 5;
  localparam int unsigned SYS_PERIOD_NS  = 50;
  localparam int unsigned START_MIN_NS   = 15;
  localparam int unsigned START_MIN_CYC  = ((START_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS) < 1 ? 1 :
                                           ((START_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

  typedef logic [RES_W-1:0] dapr_word_t;

  typedef enum logic [1:0] {
    DAPR_IDLE,
    DAPR_CONV
  } dapr_state_t;

  typedef struct packed {
    logic conversion_start_strobe_n;
    logic channel_select;
    logic conv_clk;
    logic cs_n;
    logic rd_n;
  } dapr_ctrl_t;

  typedef struct packed {
    dapr_word_t a_in0;
    dapr_word_t a_in1;
    dapr_word_t b_in0;
    dapr_word_t b_in1;
  } dapr_samples_t;

  typedef struct packed {
    dapr_state_t   state;
    logic [TICK_W-1:0] ticks;
    logic          pair_sel;
    dapr_word_t    hold_a;
    dapr_word_t    hold_b;
    dapr_samples_t results;
    logic          conv_n_d;
    logic          clk_d;
    logic          rd_n_d;
    logic          read_b_next;
    logic          busy;
    dapr_word_t    data;
    logic          data_oe;
  } dapr_st_t;

  localparam logic [TICK_W-1:0] TICKS_ZERO = 5'h00;
  localparam logic [TICK_W-1:0] TICKS_DONE = 5'(CONV_TICKS);
  localparam dapr_word_t        WORD_ZERO  = 12'h000;
endpackage

// ==== tb/dapr_props.sv ====
// checker: busy and readback timing
`timescale 1ns/1ns
module dapr_props
  import dapr_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       srst_in,
  input wire dapr_ctrl_t ctrl_in,
  input wire logic       busy_out,
  input wire dapr_word_t data_out,
  input wire logic       data_oe_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  a_start_busy: assert property ($fell(ctrl_in[4]) && !busy_out |=> busy_out) else $error("no busy");
  a_busy_idle: assert property (!busy_out && !$fell(ctrl_in[4]) |=> !busy_out) else $error("stray busy");
  a_busy_steps: assert property (busy_out && !ctrl_in[2] |=> busy_out) else $error("busy off clock");
  a_data_hold: assert property (!$rose(data_oe_out) |-> $stable(data_out)) else $error("data moved");
  a_conv_end: assert property ($fell(busy_out) |-> $past(ctrl_in[2])) else $error("busy end off clock");
  a_oe_follow: assert property (1'b1 |=> data_oe_out == $past(!ctrl_in[1] && !ctrl_in[0])) else $error("oe wrong");
  a_cs_refuse: assert property (ctrl_in[1] |=> $stable(data_out)) else $error("read without select");
  c_busy: cover property ($fell(busy_out));
  c_read: cover property ($rose(data_oe_out));
  c_two: cover property ($rose(data_oe_out) ##4 $rose(data_oe_out));
endmodule
bind dapr_top dapr_props dapr_props_i (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .ctrl_in(ctrl_in),
  .busy_out(busy_out), .data_out(data_out), .data_oe_out(data_oe_out));

// ==== tb/dapr_host.sv ====
// host model: start, conversion clock, reads
`timescale 1ns/1ns
module dapr_host
  import dapr_pkg::*;
(
  input  wire logic  clk_in,
  output dapr_ctrl_t ctrl_out = 5'h13
);
  task automatic convert(input logic sel, input int half);
    @(posedge clk_in) ctrl_out[4:3] <= {1'b0, sel};
    @(posedge clk_in) ctrl_out[4] <= 1'b1;
    repeat (32) begin
      repeat (half) @(posedge clk_in);
      ctrl_out[2] <= !ctrl_out[2];
    end
  endtask
  task automatic read(input logic cs, input logic sel);
    @(posedge clk_in) ctrl_out <= {1'b1, sel, 1'b0, !cs, 1'b0};
    repeat (2) @(posedge clk_in);
    ctrl_out[1:0] <= 2'b11;
    @(posedge clk_in);
  endtask
endmodule

// ==== tb/dapr_top_bench.sv ====
// bench: conversions and alternating reads
`timescale 1ns/1ns
module dapr_top_bench;
  import dapr_pkg::*;
  logic          clk = 1'b0, rst = 1'b1, busy, oe, s, b;
  dapr_ctrl_t    ctrl;
  dapr_samples_t v, ain = '0;
  dapr_word_t    dout, res [4] = '{default: 12'h000}, exp_q [$];
  int            num_errors = 0, num_checks = 0;
  initial forever #25 clk = ~clk;
  dapr_top dapr_top_i (.sys_clk_in(clk), .srst_in(rst), .ctrl_in(ctrl), .analog_in(ain),
    .busy_out(busy), .data_out(dout), .data_oe_out(oe));
  dapr_host dapr_host_i (.clk_in(clk), .ctrl_out(ctrl));
  task automatic check(input dapr_word_t got, input dapr_word_t exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial forever begin
    @(posedge oe) #1;
    if (exp_q.size() == 0) num_errors++;
    else check(dout, exp_q.pop_front());
  end
  initial begin
    void'($urandom(15356));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = 48'({$urandom, $urandom});
      s = 1'($urandom);
      ain <= v;
      dapr_host_i.convert(s, 1 + i % 3);
      {res[s], res[2 + s]} = s ? {v.a_in1, v.b_in1} : {v.a_in0, v.b_in0};
      check(12'(busy), 12'h000);
      b = 1'b0;
      for (int k = 0; k < 4; k++) begin
        s = 1'($urandom);
        if (k != 1) exp_q.push_back(res[{b, s}]);
        if (k != 1) b = !b;
        dapr_host_i.read(k != 1, s);
      end
    end
    if (exp_q.size() != 0) num_errors++;
    print_verdict();
  end
endmodule
